// ===== verilog/cop_port.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cop_port
  import cop_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic master_compare_match_in,
  input wire logic [3:0] compare_match_in,
  input wire logic [7:0] high_addr_in,
  input wire logic pa7_pin_in,
  output logic [7:3] pa_pin_out,
  output logic [7:3] pa_pin_oe_out,
  output logic [7:0] pb_pin_out,
  output logic bus_clk_out,
  output logic address_latch_strobe_out,
  output logic first_port_read_enable_out,
  output logic second_port_read_enable_out,
  output logic second_port_write_strobe_out,
  output logic external_access_out
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Next pin value for a compare event
  function automatic logic cmp_next(input logic [1:0] pair, input logic prev);
    logic res;
    res = prev;
    case (cop_cmp_type'(pair))
      CMP_TOGGLE: res = ~prev;
      CMP_LOW: res = 1'b0;
      CMP_HIGH: res = 1'b1;
      default: res = prev;
    endcase
    return res;
  endfunction

  // Register select
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // ****************************************************************
  // Phases and pin input
  // ****************************************************************
  cop_phase_if ph ();
  logic pa7_sync;

  cop_phase_gen u_phase (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ph(ph.src)
  );

  cop_sync #(
    .WIDTH(1)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(pa7_pin_in),
    .q_out(pa7_sync)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  cop_state_type s_r;
  cop_state_type s_nxt;
  logic ev_m;
  logic [3:0] ev_d;
  logic force_wr;

  assign force_wr = wr_in && hit(addr_in, OFS_FORCE);

  // Pending compare events, match pulses and forced writes
  always_comb begin
    ev_m = s_r.ev_master | master_compare_match_in | (force_wr & wdata_in[BIT7_POS]);
    ev_d = s_r.ev_ded | compare_match_in | (force_wr ? wdata_in[6:3] : 4'h0);
  end

  always_comb begin
    logic owned;
    logic [1:0] pair;
    owned = 1'b0;
    pair = 2'h0;
    s_nxt = s_r;
    s_nxt.ext_acc = 1'b0;
    s_nxt.rdata = '0;
    s_nxt.ev_master = ev_m;
    s_nxt.ev_ded = ev_d;

    // Register writes
    if (wr_in) begin
      if (hit(addr_in, OFS_FIRST_PORT)) begin
        s_nxt.pa_gp = wdata_in[7:0];
      end
      if (hit(addr_in, OFS_SECOND_PORT)) begin
        if (s_r.expanded) begin
          s_nxt.ext_acc = 1'b1;
        end else begin
          s_nxt.pb_wpend = ~wdata_in[7:0];
          s_nxt.pb_wvalid = 1'b1;
        end
      end
      if (hit(addr_in, OFS_DIRECTION)) begin
        s_nxt.pa7_dir = wdata_in[BIT7_POS];
      end
      if (hit(addr_in, OFS_MASTER_MASK)) begin
        s_nxt.mmask = wdata_in[7:3];
      end
      if (hit(addr_in, OFS_MASTER_VALUE)) begin
        s_nxt.mval = wdata_in[7:3];
      end
      if (hit(addr_in, OFS_COMPARE_CTRL)) begin
        s_nxt.cmp_ctrl = wdata_in[7:0];
      end
      if (hit(addr_in, OFS_MODE)) begin
        s_nxt.expanded = wdata_in[MODE_EXPANDED_POS];
      end
    end

    // Register reads, data stands one cycle later
    if (rd_in) begin
      if (hit(addr_in, OFS_FIRST_PORT)) begin
        s_nxt.rdata = {pa7_sync, s_r.oc_pin, 3'h0};
      end
      if (hit(addr_in, OFS_SECOND_PORT)) begin
        if (s_r.expanded) begin
          s_nxt.ext_acc = 1'b1;
        end else begin
          s_nxt.rdata = ~s_r.pb_latch;
        end
      end
      if (hit(addr_in, OFS_DIRECTION)) begin
        s_nxt.rdata = {s_r.pa7_dir, 7'h00};
      end
      if (hit(addr_in, OFS_MASTER_MASK)) begin
        s_nxt.rdata = {s_r.mmask, 3'h0};
      end
      if (hit(addr_in, OFS_MASTER_VALUE)) begin
        s_nxt.rdata = {s_r.mval, 3'h0};
      end
      if (hit(addr_in, OFS_COMPARE_CTRL)) begin
        s_nxt.rdata = s_r.cmp_ctrl;
      end
      if (hit(addr_in, OFS_MODE)) begin
        s_nxt.rdata = {7'h00, s_r.expanded};
      end
    end

    // First port pins update on the bus-clock fall strobe
    if (ph.bus_fall) begin
      for (int i = 0; i < 4; i++) begin
        pair = s_r.cmp_ctrl[2*i +: 2];
        owned = s_r.mmask[i] | (pair != 2'h0);
        if (s_r.mmask[i] && ev_m) begin
          s_nxt.oc_pin[i] = s_r.mval[i];
        end else if ((pair != 2'h0) && ev_d[i]) begin
          s_nxt.oc_pin[i] = cmp_next(pair, s_r.oc_pin[i]);
        end else if (!owned) begin
          s_nxt.oc_pin[i] = s_r.pa_gp[i+COMPARE_LSB];
        end
      end
      if (s_r.mmask[4]) begin
        if (ev_m) begin
          s_nxt.pa7_pin = s_r.mval[4];
        end
      end else begin
        s_nxt.pa7_pin = s_r.pa_gp[BIT7_POS];
      end
      s_nxt.ev_master = 1'b0;
      s_nxt.ev_ded = 4'h0;
    end

    // Direction and second port writes act at phase-2 fall
    if (ph.ph2_fall) begin
      s_nxt.pa7_oe = s_r.pa7_dir;
      if (!s_r.expanded && s_r.pb_wvalid) begin
        s_nxt.pb_latch = s_r.pb_wpend;
        // A write landing in this same cycle stays pending for the next fall
        if (!(wr_in && hit(addr_in, OFS_SECOND_PORT))) begin
          s_nxt.pb_wvalid = 1'b0;
        end
      end
    end

    // Expanded mode latch follows the high address while strobe is high
    if (s_r.expanded && ph.addr_strobe) begin
      s_nxt.pb_latch = ~high_addr_in;
      s_nxt.pb_wvalid = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= COP_STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Pin drive
  assign pa_pin_out = {s_r.pa7_pin, s_r.oc_pin};
  assign pa_pin_oe_out = {s_r.pa7_oe, 4'hF};
  assign pb_pin_out = ~s_r.pb_latch;

  // Bus timing and strobes
  assign bus_clk_out = ph.bus_clk;
  assign address_latch_strobe_out = ph.addr_strobe;
  assign rdata_out = DATA_W'(s_r.rdata);
  assign external_access_out = s_r.ext_acc;
  assign first_port_read_enable_out = rd_in && hit(addr_in, OFS_FIRST_PORT);
  assign second_port_read_enable_out = rd_in && hit(addr_in, OFS_SECOND_PORT)
                                       && !s_r.expanded;
  assign second_port_write_strobe_out = wr_in && hit(addr_in, OFS_SECOND_PORT)
                                        && !s_r.expanded;

endmodule
`default_nettype wire

// ===== verilog/cop_pkg.sv
`default_nettype none
package cop_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int REF_PERIOD_NS = 100;
  localparam int BUS_PERIOD_NS = 400;
  localparam int BUS_CYCLES = BUS_PERIOD_NS / REF_PERIOD_NS;
  localparam logic [1:0] PHASE_LAST = 2'(BUS_CYCLES - 1);
  localparam logic [1:0] PHASE_STROBE_HIGH = 2'h0;
  localparam logic [1:0] PHASE_PH2_FALL = 2'h2;
  localparam logic [1:0] PHASE_BUS_HIGH = 2'h2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FIRST_PORT = 8'h00;
  localparam logic [7:0] OFS_SECOND_PORT = 8'h04;
  localparam logic [7:0] OFS_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_MASTER_MASK = 8'h0C;
  localparam logic [7:0] OFS_MASTER_VALUE = 8'h10;
  localparam logic [7:0] OFS_COMPARE_CTRL = 8'h14;
  localparam logic [7:0] OFS_FORCE = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT7_POS = 7;
  localparam int COMPARE_LSB = 3;
  localparam int MODE_EXPANDED_POS = 0;

  // ****************************************************************
  // Compare mode and level pair
  // ****************************************************************
  typedef enum logic [1:0] {
    CMP_OFF,
    CMP_TOGGLE,
    CMP_LOW,
    CMP_HIGH
  } cop_cmp_type;

  // ****************************************************************
  // Block state and reset values
  // ****************************************************************
  typedef struct packed {
    logic [7:0] pa_gp;
    logic [3:0] oc_pin;
    logic pa7_pin;
    logic pa7_oe;
    logic pa7_dir;
    logic [4:0] mmask;
    logic [4:0] mval;
    logic [7:0] cmp_ctrl;
    logic expanded;
    logic ev_master;
    logic [3:0] ev_ded;
    logic [7:0] pb_latch;
    logic [7:0] pb_wpend;
    logic pb_wvalid;
    logic [7:0] rdata;
    logic ext_acc;
  } cop_state_type;

  localparam logic [7:0] SECOND_PORT_RESET = 8'hFF;
  localparam cop_state_type COP_STATE_RESET = '{
    pb_latch: SECOND_PORT_RESET,
    default: '0
  };

endpackage
`default_nettype wire

// ===== verilog/cop_phase_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cop_phase_if;
  logic bus_clk;
  logic ph2;
  logic addr_strobe;
  logic bus_fall;
  logic ph2_fall;

  modport src (output bus_clk, output ph2, output addr_strobe, output bus_fall,
               output ph2_fall);
  modport dst (input bus_clk, input ph2, input addr_strobe, input bus_fall,
               input ph2_fall);
endinterface
`default_nettype wire

// ===== verilog/cop_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cop_sync
  import cop_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cop_sync_type;

  cop_sync_type s_r;
  cop_sync_type s_nxt;

  // Two stage shift
  always_comb begin
    s_nxt.meta = d_in;
    s_nxt.stable = s_r.meta;
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.stable;

endmodule
`default_nettype wire

// ===== verilog/cop_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none
module cop_phase_gen
  import cop_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  cop_phase_if.src ph
);

  typedef struct packed {
    logic [1:0] quarter;
  } cop_phase_type;

  cop_phase_type s_r;
  cop_phase_type s_nxt;

  // Quarter counter of the bus cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.quarter = (s_r.quarter == PHASE_LAST) ? 2'h0 : 2'(s_r.quarter + 2'h1);
  end

  // State register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Phase decode: strobe, phase-2, bus clock
  assign ph.addr_strobe = (s_r.quarter == PHASE_STROBE_HIGH);
  assign ph.ph2 = (s_r.quarter == 2'h1) || (s_r.quarter == 2'h2);
  assign ph.bus_clk = (s_r.quarter >= PHASE_BUS_HIGH);
  assign ph.bus_fall = (s_r.quarter == PHASE_LAST);
  assign ph.ph2_fall = (s_r.quarter == PHASE_PH2_FALL);

endmodule
`default_nettype wire

// ===== test/cop_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module cop_port_props
  import cop_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic [7:3] pa_pin_out,
  input wire logic [7:3] pa_pin_oe_out,
  input wire logic [7:0] pb_pin_out,
  input wire logic bus_clk_out,
  input wire logic address_latch_strobe_out,
  input wire logic first_port_read_enable_out,
  input wire logic second_port_read_enable_out,
  input wire logic second_port_write_strobe_out,
  input wire logic external_access_out
);
  // ********************
  // Pin and bus timing
  // ********************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  oe_fixed_a: assert property (pa_pin_oe_out[6:3] == 4'hF)
    else $error("Compare pin enable dropped");
  pa_edge_a: assert property ($changed(pa_pin_out) |-> $fell(bus_clk_out))
    else $error("First port pin moved off bus clock fall");
  dir_edge_a: assert property ($changed(pa_pin_oe_out[7]) |-> bus_clk_out && $past(bus_clk_out))
    else $error("Bit 7 enable moved off phase-2 fall");
  pb_edge_a: assert property ($changed(pb_pin_out) |->
    $past(address_latch_strobe_out) || (bus_clk_out && $past(bus_clk_out)))
    else $error("Second port pins moved at wrong time");
  rd_pb_a: assert property (second_port_read_enable_out |=> rdata_out == $past(pb_pin_out))
    else $error("Second port read data wrong");
  rd_pa_a: assert property (first_port_read_enable_out |=>
    rdata_out[6:0] == {$past(pa_pin_out[6:3]), 3'h0})
    else $error("First port read data wrong");
  ext_acc_a: assert property (external_access_out |->
    $past(addr_in == OFS_SECOND_PORT && (rd_in || wr_in)) && !$past(second_port_read_enable_out))
    else $error("External access without port access");
  int_acc_a: assert property (second_port_read_enable_out || second_port_write_strobe_out |->
    addr_in == OFS_SECOND_PORT ##1 !external_access_out)
    else $error("Internal and external access together");
endmodule

bind cop_port cop_port_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_cop_port_props (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .pa_pin_out(pa_pin_out),
  .pa_pin_oe_out(pa_pin_oe_out), .pb_pin_out(pb_pin_out), .bus_clk_out(bus_clk_out),
  .address_latch_strobe_out(address_latch_strobe_out),
  .first_port_read_enable_out(first_port_read_enable_out),
  .second_port_read_enable_out(second_port_read_enable_out),
  .second_port_write_strobe_out(second_port_write_strobe_out),
  .external_access_out(external_access_out));
`default_nettype wire

// ===== test/cop_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module cop_pins_model (
  input wire logic ref_clk_in,
  input wire logic pin_drive_in,
  input wire logic pin_oe_in,
  input wire logic ext_en_in,
  input wire logic ext_level_in,
  output logic pin_level_out
);
  // ********************
  // Bit 7 pin wire
  // ********************
  logic float_r = 1'b0;

  // Undriven pin wanders every cycle
  always_ff @(posedge ref_clk_in) begin
    float_r <= ~float_r;
  end

  // Device driver wins, else outside driver, else floating
  assign pin_level_out = pin_oe_in ? pin_drive_in : (ext_en_in ? ext_level_in : float_r);
endmodule
`default_nettype wire

// ===== test/cop_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cop_port_tb
  import cop_pkg::*;
;
  // ********************
  // Stimulus and checks
  // ********************
  typedef struct {
    logic [7:0] dat, msk, mvl, ctl, frc;
    logic [4:0] ev, exp;
  } cop_row_type;
  // Data, mask, value, control, force, events, expected pins 7..3
  cop_row_type rows [9] = '{
    '{8'hF8, 8'h00, 8'h00, 8'h00, 8'h00, 5'h00, 5'h1F},
    '{8'h00, 8'h00, 8'h00, 8'h39, 8'h00, 5'h00, 5'h00},
    '{8'h00, 8'h00, 8'h00, 8'h39, 8'h78, 5'h00, 5'h05},
    '{8'h00, 8'h88, 8'h80, 8'h39, 8'h88, 5'h00, 5'h14},
    '{8'hF8, 8'h88, 8'h00, 8'h00, 8'h00, 5'h00, 5'h1E},
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 5'h00, 5'h00},
    '{8'hF8, 8'h40, 8'h00, 8'hC0, 8'h00, 5'h18, 5'h17},
    '{8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 5'h08, 5'h08},
    '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 5'h01, 5'h01}};
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic master_compare_match_in = 1'b0;
  logic [3:0] compare_match_in = 4'h0;
  logic [7:0] high_addr_in = 8'h00;
  logic ext_en = 1'b0;
  logic ext_lvl = 1'b0;
  logic pa7_pin_in;
  logic [7:0] rdata_out, pb_pin_out, d;
  logic ext_acc, e;
  logic [7:3] pa_pin_out, pa_pin_oe_out;
  int bad_count = 0;
  int checked = 0;

  // Clock
  always #50 ref_clk_in = ~ref_clk_in;

  cop_port i_cop_port (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .master_compare_match_in(master_compare_match_in), .compare_match_in(compare_match_in),
    .high_addr_in(high_addr_in), .pa7_pin_in(pa7_pin_in), .pa_pin_out(pa_pin_out),
    .pa_pin_oe_out(pa_pin_oe_out), .pb_pin_out(pb_pin_out), .bus_clk_out(),
    .address_latch_strobe_out(), .first_port_read_enable_out(),
    .second_port_read_enable_out(), .second_port_write_strobe_out(),
    .external_access_out(ext_acc));
  cop_pins_model i_cop_pins_model (.ref_clk_in(ref_clk_in), .pin_drive_in(pa_pin_out[7]),
    .pin_oe_in(pa_pin_oe_out[7]), .ext_en_in(ext_en), .ext_level_in(ext_lvl),
    .pin_level_out(pa7_pin_in));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    e = ext_acc;
  endtask

  task automatic pause();
    repeat (8) @(posedge ref_clk_in);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    bad_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    pause();
    chk(pb_pin_out, 8'h00);
    chk({3'h0, pa_pin_oe_out}, 8'h0F);
    ext_en <= 1'b1;
    wr(OFS_FIRST_PORT, 8'h80);
    for (int lvl = 0; lvl < 2; lvl++) begin
      ext_lvl <= lvl[0];
      pause();
      rd(OFS_FIRST_PORT);
      chk({7'h0, d[7]}, {7'h0, lvl[0]});
    end
    ext_en <= 1'b0;
    wr(OFS_DIRECTION, 8'h80);
    pause();
    chk({3'h0, pa_pin_oe_out}, 8'h1F);
    chk({7'h0, pa_pin_out[7]}, 8'h01);
    foreach (rows[i]) begin
      wr(OFS_FIRST_PORT, rows[i].dat);
      wr(OFS_MASTER_MASK, rows[i].msk);
      wr(OFS_MASTER_VALUE, rows[i].mvl);
      wr(OFS_COMPARE_CTRL, rows[i].ctl);
      wr(OFS_FORCE, rows[i].frc);
      @(posedge ref_clk_in);
      master_compare_match_in <= rows[i].ev[4];
      compare_match_in <= rows[i].ev[3:0];
      @(posedge ref_clk_in);
      master_compare_match_in <= 1'b0;
      compare_match_in <= 4'h0;
      pause();
      rd(OFS_FIRST_PORT);
      chk({3'h0, d[7:3]}, {3'h0, rows[i].exp});
      chk({3'h0, pa_pin_out}, {3'h0, rows[i].exp});
    end
    wr(OFS_SECOND_PORT, 8'hA5);
    pause();
    chk(pb_pin_out, 8'hA5);
    rd(OFS_SECOND_PORT);
    chk(d, 8'hA5);
    chk({7'h0, e}, 8'h00);
    rd(8'h3C);
    chk(d, 8'h00);
    high_addr_in <= 8'hC3;
    wr(OFS_MODE, 8'h01);
    pause();
    chk(pb_pin_out, 8'hC3);
    rd(OFS_SECOND_PORT);
    chk(d, 8'h00);
    chk({7'h0, e}, 8'h01);
    wr(OFS_SECOND_PORT, 8'h11);
    high_addr_in <= 8'h7E;
    pause();
    chk(pb_pin_out, 8'h7E);
    // Reset again mid-run, from expanded mode
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    chk(pb_pin_out, 8'h00);
    chk({3'h0, pa_pin_out}, 8'h00);
    rst_in <= 1'b0;
    pause();
    chk({3'h0, pa_pin_oe_out}, 8'h0F);
    chk(pb_pin_out, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
